// >>> hdl/uap_defines.vh
// Register map, field layout, reset values and encodings of the upper address I/O port
// Assumes an APB slave with 32-bit data and one aligned word per register
`ifndef UAP_DEFINES_VH
`define UAP_DEFINES_VH

// Register indices, the byte address is four times the index
`define UAP_IDX_DATA_LATCH 6
`define UAP_IDX_DIRECTION 8
`define UAP_IDX_FUNCTION 9

// Register byte addresses
`define UAP_ADDR_DATA_LATCH 12'h018
`define UAP_ADDR_DIRECTION 12'h020
`define UAP_ADDR_FUNCTION 12'h024
`define UAP_ADDR_PIN_LEVEL 12'h00C
`define UAP_ADDR_CONFIG_VIEW 12'h010

// Address decode
`define UAP_ADDR_WIDTH 12

// Field layout
`define UAP_PORT_WIDTH 8
`define UAP_ADDR_HIGH_LSB 16

// Reset values
`define UAP_RST_DATA_LATCH 8'h00
`define UAP_RST_DIRECTION 8'h00
`define UAP_RST_FUNCTION 8'h00

// Pin mode encodings {function, direction}
`define UAP_MODE_INPUT 2'b00
`define UAP_MODE_OUTPUT 2'b01
`define UAP_MODE_RSVD 2'b10
`define UAP_MODE_ADDRESS 2'b11

`endif

// >>> hdl/uap_sync.v
// Two-flip-flop synchroniser for a group of pin inputs
// Assumes inputs come from outside the clock domain
`timescale 1ns/1ps
module uap_sync #(
    parameter WIDTH = 8
) (
    input wire clock_i,
    input wire reset_n_i,
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule

// >>> hdl/uap_port.v
// Upper address I/O port: eight pins as input, output or address lines 16 to 23
// Assumes an APB master on clock_i and an external bus controller giving the address
//
// Overview of operation
// - Eight pins, each configured on its own.
// - Function bit clear: direction 0 gives input, 1 gives output.
// - Pins can carry upper memory address bits 16 to 23.
// - Direction and function both 1: pin n drives address bit 16+n.
// - Reset clears latch, direction and function, so all pins input.
// - Data register is readable and writable; latch drives output pins.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "uap_defines.vh"
module uap_port #(
    parameter WIDTH = `UAP_PORT_WIDTH
) (
    input wire clock_i,
    input wire reset_n_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [31:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    input wire [23:0] bus_address_i,
    input wire [WIDTH-1:0] pin_in_i,
    output reg [WIDTH-1:0] pin_out_o,
    output reg [WIDTH-1:0] pin_oe_n_o
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [WIDTH-1:0] data_latch_q;
    reg [WIDTH-1:0] direction_q;
    reg [WIDTH-1:0] function_q;
    reg [31:0] prdata_q;
    reg pslverr_q;
    reg [WIDTH-1:0] pin_out_d;
    reg [WIDTH-1:0] pin_oe_n_d;
    reg [31:0] rdata_d;
    reg hit_d;
    wire [WIDTH-1:0] pin_level;
    wire [WIDTH-1:0] addr_high;
    wire setup;
    wire wr_en;
    wire [`UAP_ADDR_WIDTH-1:0] addr;
    wire sel_latch;
    wire sel_direction;
    wire sel_function;
    wire wr_latch;
    wire wr_direction;
    wire wr_function;
    integer i;

    function [1:0] pin_mode;
        input dir_bit;
        input fn_bit;
        begin
            pin_mode = {fn_bit, dir_bit};
        end
    endfunction

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Select one register by byte address
    function reg_match;
        input [`UAP_ADDR_WIDTH-1:0] addr_in;
        input [`UAP_ADDR_WIDTH-1:0] target;
        begin
            reg_match = (addr_in == target);
        end
    endfunction

    // Register byte from the low lane of the write data
    function [WIDTH-1:0] write_byte;
        input [31:0] wdata;
        begin
            write_byte = wdata[WIDTH-1:0];
        end
    endfunction

    assign addr = paddr_i[`UAP_ADDR_WIDTH-1:0];
    assign setup = psel_i && !penable_i;
    assign wr_en = psel_i && penable_i && pwrite_i;
    assign addr_high = bus_address_i[`UAP_ADDR_HIGH_LSB +: WIDTH];
    assign pready_o = 1'b1;
    assign prdata_o = prdata_q;
    assign pslverr_o = pslverr_q;

    // ----------------------------------------------------------------
    // Pin input synchroniser
    // ----------------------------------------------------------------
    uap_sync #(
        .WIDTH(WIDTH)
    ) u_sync (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .async_i(pin_in_i),
        .sync_o(pin_level)
    );

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    assign sel_latch = reg_match(addr, `UAP_ADDR_DATA_LATCH);
    assign sel_direction = reg_match(addr, `UAP_ADDR_DIRECTION);
    assign sel_function = reg_match(addr, `UAP_ADDR_FUNCTION);
    assign wr_latch = wr_en && sel_latch;
    assign wr_direction = wr_en && sel_direction;
    assign wr_function = wr_en && sel_function;

    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            data_latch_q <= `UAP_RST_DATA_LATCH;
        end else if (wr_latch) begin
            data_latch_q <= write_byte(pwdata_i);
        end
    end

    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            direction_q <= `UAP_RST_DIRECTION;
        end else if (wr_direction) begin
            direction_q <= write_byte(pwdata_i);
        end
    end

    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            function_q <= `UAP_RST_FUNCTION;
        end else if (wr_function) begin
            function_q <= write_byte(pwdata_i);
        end
    end

    // ----------------------------------------------------------------
    // Read decode
    // ----------------------------------------------------------------
    always @* begin
        rdata_d = 32'h0000_0000;
        hit_d = 1'b1;
        case (addr)
            `UAP_ADDR_DATA_LATCH: begin
                rdata_d[WIDTH-1:0] = data_latch_q;
            end
            `UAP_ADDR_DIRECTION: begin
                rdata_d = 32'h0000_0000;
            end
            `UAP_ADDR_FUNCTION: begin
                rdata_d = 32'h0000_0000;
            end
            `UAP_ADDR_PIN_LEVEL: begin
                rdata_d[WIDTH-1:0] = pin_level;
            end
            `UAP_ADDR_CONFIG_VIEW: begin
                rdata_d[WIDTH-1:0] = direction_q;
                rdata_d[8 +: WIDTH] = function_q;
            end
            default: begin
                hit_d = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Read capture
    // ----------------------------------------------------------------
    // read data capture
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup) begin
            prdata_q <= pwrite_i ? 32'h0000_0000 : rdata_d;
        end
    end

    // Unmapped address error
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pslverr_q <= 1'b0;
        end else if (setup) begin
            pslverr_q <= !hit_d;
        end
    end

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    always @* begin
        pin_out_d = {WIDTH{1'b0}};
        pin_oe_n_d = {WIDTH{1'b1}};
        for (i = 0; i < WIDTH; i = i + 1) begin
            case (pin_mode(direction_q[i], function_q[i]))
                `UAP_MODE_OUTPUT: begin
                    pin_out_d[i] = data_latch_q[i];
                    pin_oe_n_d[i] = 1'b0;
                end
                `UAP_MODE_ADDRESS: begin
                    pin_out_d[i] = addr_high[i];
                    pin_oe_n_d[i] = 1'b0;
                end
                default: begin
                    pin_out_d[i] = 1'b0;
                    pin_oe_n_d[i] = 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pin output registers
    // ----------------------------------------------------------------
    // registered pin output values, from the latch or the address per pin
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_out_o <= {WIDTH{1'b0}};
        end else begin
            pin_out_o <= pin_out_d;
        end
    end

    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_oe_n_o <= {WIDTH{1'b1}};
        end else begin
            pin_oe_n_o <= pin_oe_n_d;
        end
    end
endmodule

// >>> bench/uap_bus_model.sv
// External bus controller model
// Assumes the bench clock and a run enable
`timescale 1ns/1ps
module uap_bus_model (
    input logic clock_i,
    input logic run_i,
    output logic [23:0] bus_address_o
);
    initial bus_address_o = 24'h00_0000;
    always @(posedge clock_i) if (run_i) bus_address_o <= bus_address_o + 24'h13_5701;
endmodule

// >>> bench/uap_port_assertions.sv
// Pin, read data and ready assertions for the port
// Assumes a bind to uap_port
`timescale 1ns/1ps
`include "uap_defines.vh"
module uap_port_assertions #(parameter WIDTH = 8) (
    input logic clock_i,
    input logic reset_n_i,
    input logic psel_i,
    input logic penable_i,
    input logic pwrite_i,
    input logic [31:0] paddr_i,
    input logic [31:0] pwdata_i,
    input logic [23:0] bus_address_i,
    input logic [31:0] prdata_o,
    input logic pready_o,
    input logic pslverr_o,
    input logic [WIDTH-1:0] pin_out_o,
    input logic [WIDTH-1:0] pin_oe_n_o
);
    logic wr_q;
    logic [WIDTH-1:0] dir_q, fn_q, lat_q;
    wire wr = psel_i && penable_i && pwrite_i;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_q <= 1'b0;
            dir_q <= '0;
            fn_q <= '0;
            lat_q <= '0;
        end else begin
            wr_q <= wr;
            if (wr && paddr_i[11:0] == `UAP_ADDR_DATA_LATCH) lat_q <= pwdata_i[WIDTH-1:0];
            if (wr && paddr_i[11:0] == `UAP_ADDR_DIRECTION) dir_q <= pwdata_i[WIDTH-1:0];
            if (wr && paddr_i[11:0] == `UAP_ADDR_FUNCTION) fn_q <= pwdata_i[WIDTH-1:0];
        end
    end
    property p_rst; $rose(reset_n_i) |-> pin_oe_n_o == '1 && pin_out_o == '0; endproperty
    a_rst: assert property (p_rst) else $error("reset");
    property p_oe; !wr_q |-> pin_oe_n_o == ~dir_q; endproperty
    a_oe: assert property (p_oe) else $error("enable");
    property p_adr; !wr_q |-> ((pin_out_o ^ $past(bus_address_i[23:16])) & dir_q & fn_q) == '0; endproperty
    a_adr: assert property (p_adr) else $error("address");
    property p_gpio; !wr_q |-> ((pin_out_o ^ lat_q) & dir_q & ~fn_q) == '0; endproperty
    a_gpio: assert property (p_gpio) else $error("output latch");
    property p_rd;
        psel_i && penable_i && !pwrite_i && paddr_i[11:0] == `UAP_ADDR_DATA_LATCH |-> prdata_o == 32'(lat_q);
    endproperty
    a_rd: assert property (p_rd) else $error("read data");
    property p_rdy; psel_i && penable_i |-> pready_o; endproperty
    a_rdy: assert property (p_rdy) else $error("ready");
endmodule

// >>> bench/testbench.sv
// Bench for the port
// Assumes design, model, checker
`timescale 1ns/1ps
`include "uap_defines.vh"
module testbench;
    logic clk = 1'b0, rst_n = 1'b0, sel = 1'b0, en = 1'b0, wr = 1'b0, run = 1'b0, rdy;
    logic [31:0] adr = 32'h0, wd = 32'h0, rdat, rd;
    logic [23:0] bus;
    logic [7:0] po, oe_n, pins = 8'hA5;
    logic err, es;
    int err_total = 0, checks_done = 0;
    uap_port uap_port_inst (.clock_i(clk), .reset_n_i(rst_n), .psel_i(sel), .penable_i(en), .pwrite_i(wr),
        .paddr_i(adr), .pwdata_i(wd), .prdata_o(rdat), .pready_o(rdy), .pslverr_o(err),
        .bus_address_i(bus), .pin_in_i(pins), .pin_out_o(po), .pin_oe_n_o(oe_n));
    uap_bus_model uap_bus_model_inst (.clock_i(clk), .run_i(run), .bus_address_o(bus));
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %0t %h %h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        sel <= 1'b1;
        wr <= w;
        adr <= {20'h0, a};
        wd <= {24'h0, d};
        @(posedge clk);
        en <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        rd = rdat;
        es = err;
        sel <= 1'b0;
        en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_idle;
        apb(1'b0, `UAP_ADDR_DATA_LATCH, 8'h00);
        chk({rd[23:0], oe_n}, 32'hFF);
    endtask
    task automatic t_gpio;
        apb(1'b1, `UAP_ADDR_DATA_LATCH, 8'h5A);
        apb(1'b1, `UAP_ADDR_DIRECTION, 8'h0F);
        apb(1'b0, `UAP_ADDR_DATA_LATCH, 8'h00);
        chk({rd[19:0], oe_n, po[3:0]}, 32'h5_AF0A);
    endtask
    task automatic t_addr;
        apb(1'b1, `UAP_ADDR_DIRECTION, 8'hFF);
        apb(1'b1, `UAP_ADDR_FUNCTION, 8'hF0);
        run <= 1'b1;
        repeat (9) @(posedge clk);
        run <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'(po), 32'({bus[23:20], 4'hA}));
        apb(1'b1, `UAP_ADDR_DIRECTION, 8'h0F);
        @(posedge clk);
        chk(32'(oe_n), 32'hF0);
    endtask
    task automatic t_regs;
        apb(1'b0, `UAP_ADDR_PIN_LEVEL, 8'h00);
        chk(rd, 32'hA5);
        pins <= 8'h3C;
        repeat (3) @(posedge clk);
        apb(1'b0, `UAP_ADDR_PIN_LEVEL, 8'h00);
        chk(rd, 32'h3C);
        apb(1'b0, `UAP_ADDR_CONFIG_VIEW, 8'h00);
        chk(rd, 32'hF00F);
        apb(1'b0, `UAP_ADDR_DIRECTION, 8'h00);
        chk({rd[30:0], es}, 32'h0);
        apb(1'b0, 12'h0FC, 8'h00);
        chk({rd[30:0], es}, 32'h1);
    endtask
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_idle;
        t_gpio;
        t_addr;
        t_regs;
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        t_idle;
        stop_test;
    end
    initial begin
        #5000;
        err_total++;
        stop_test;
    end
endmodule
bind uap_port uap_port_assertions #(.WIDTH(WIDTH)) uap_port_assertions_inst (.clock_i(clock_i),
    .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .bus_address_i(bus_address_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o));
